/* hw/adc_bus_consts.svh */
// Purpose: constants of the parallel host port of the converter
// Assumes: 25 MHz system clock
// Notes:   the conversion count is in master clock half periods
`ifndef ADC_BUS_CONSTS_SVH
`define ADC_BUS_CONSTS_SVH

`define DATA_W          12
`define CTRL_RST        12'h000
`define RESULT_RST      12'h000
`define CONV_HALF_CYC   27
`define ID_LSB          5
`define ZERO_BIT4       4

`endif

/* hw/adc_bus_pkg.sv */
// Purpose: types of the parallel host port
// Assumes: widths written out here, not taken from the header
// Notes:   none
package adc_bus_pkg;

    typedef enum logic [1:0] {
        IDLE,
        CONVERT,
        LOAD
    } conv_state_e;

    typedef struct packed {
        logic chipSelN;
        logic readN;
        logic writeN;
        logic wordByteSel;
    } host_ctl_s;

    typedef struct packed {
        logic [11:0] value;
        logic [1:0]  channel;
    } result_s;

endpackage

/* hw/adc_parallel_bus_interface.sv */
// What this block does
// - Word mode moves full word at once
// - Byte mode uses low lines, bit8 selects
// - Ten-bit word reads zero lines 0,1
// - Byte low: low byte on lines 0-7
// - Ten-bit low byte: two zeros, six bits
// - Byte high: top four bits lines 0-3
// - High read: line4 zero, channel 5-6
// - Upper lines idle in byte mode
// - Bus driven only under strobes, else released
// - Busy rises after start fall, holds
// - Busy falls as result is loaded
// - Track resumes as busy falls
// - Conversion spans 13.5 master clocks
// - Start falling edge holds, starts conversion
// - Start rising edge wakes from auto power-down
// - Read with select puts result on bus
// - Write with select loads control register
//
// Purpose: host port and conversion sequencing of a four-channel converter
// Assumes: all inputs synchronous to clk; master clock sampled as a level
// Notes:   output enable of each data line is low while driving
`timescale 1ns/100ps
`include "adc_bus_consts.svh"

module adc_parallel_bus_interface #(
    parameter bit TEN_BIT = 1'b0
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire adc_bus_pkg::host_ctl_s hostCtl,
    input  wire logic [11:0]           dataIn,
    output logic [11:0]                dataOut,
    output logic [11:0]                dataOe,
    input  wire logic                  conversion_start_n,
    input  wire logic                  master_clock_in,
    input  wire adc_bus_pkg::result_s  sampleIn,
    input  wire logic                  autoPowerDown,
    output logic                       busy,
    output logic                       trackHold,
    output logic                       poweredUp,
    output logic [11:0]                controlWord,
    output logic                       controlLoad
);
    import adc_bus_pkg::*;

    // ----------------------------------------
    // Edge detection
    // ----------------------------------------
    logic startPrev_r, startPrev_nxt;
    logic mclkPrev_r, mclkPrev_nxt;
    logic readPrev_r, readPrev_nxt;
    logic startFall, startRise, mclkEdge, readStart;

    always_comb begin
        startPrev_nxt = conversion_start_n;
        mclkPrev_nxt  = master_clock_in;
        readPrev_nxt  = hostCtl.readN;
        startFall     = startPrev_r & ~conversion_start_n;
        startRise     = ~startPrev_r & conversion_start_n;
        // Both edges count: 13.5 periods are 27 half periods
        mclkEdge      = mclkPrev_r ^ master_clock_in;
        readStart     = readPrev_r & ~hostCtl.readN & ~hostCtl.chipSelN;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            startPrev_r <= 1'b1;
            mclkPrev_r  <= 1'b0;
            readPrev_r  <= 1'b1;
        end else begin
            startPrev_r <= startPrev_nxt;
            mclkPrev_r  <= mclkPrev_nxt;
            readPrev_r  <= readPrev_nxt;
        end
    end

    // ----------------------------------------
    // Conversion sequencing
    // ----------------------------------------
    conv_state_e state_r, state_nxt;
    logic [4:0]  halfCnt_r, halfCnt_nxt;
    logic        busy_r, busy_nxt;
    logic        hold_r, hold_nxt;
    logic        up_r, up_nxt;
    result_s     result_r, result_nxt;

    always_comb begin
        state_nxt   = state_r;
        halfCnt_nxt = halfCnt_r;
        busy_nxt    = busy_r;
        hold_nxt    = hold_r;
        up_nxt      = up_r;
        result_nxt  = result_r;
        if (startRise && !up_r) begin
            up_nxt = 1'b1;
        end
        unique case (state_r)
            IDLE: begin
                if (startFall && up_r) begin
                    state_nxt   = CONVERT;
                    hold_nxt    = 1'b1;
                    busy_nxt    = 1'b1;
                    halfCnt_nxt = 5'h00;
                end
            end
            CONVERT: begin
                if (mclkEdge) begin
                    halfCnt_nxt = halfCnt_r + 5'h01;
                    if (halfCnt_r == 5'(`CONV_HALF_CYC - 1)) begin
                        state_nxt = LOAD;
                    end
                end
            end
            LOAD: begin
                // Result latched in the same cycle busy drops
                result_nxt = sampleIn;
                hold_nxt   = 1'b0;
                state_nxt  = IDLE;
                busy_nxt   = 1'b0;
                if (autoPowerDown) begin
                    up_nxt = 1'b0;
                end
            end
            default: begin
                // Unused code: fall back to idle, busy and hold cleared
                state_nxt = IDLE;
                busy_nxt  = 1'b0;
                hold_nxt  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r   <= IDLE;
            halfCnt_r <= 5'h00;
            busy_r    <= 1'b0;
            hold_r    <= 1'b0;
            up_r      <= 1'b1;
            result_r  <= '{value: `RESULT_RST, channel: 2'h0};
        end else begin
            state_r   <= state_nxt;
            halfCnt_r <= halfCnt_nxt;
            busy_r    <= busy_nxt;
            hold_r    <= hold_nxt;
            up_r      <= up_nxt;
            result_r  <= result_nxt;
        end
    end

    // ----------------------------------------
    // Host bus
    // ----------------------------------------
    logic [11:0] dOut_r, dOut_nxt;
    logic [11:0] dOe_r, dOe_nxt;
    logic [11:0] ctrl_r, ctrl_nxt;
    logic        ctrlLd_r, ctrlLd_nxt;
    logic [11:0] readWord;
    logic        reading, writing, hiByte;

    always_comb begin
        reading  = ~hostCtl.chipSelN & ~hostCtl.readN;
        writing  = ~hostCtl.chipSelN & ~hostCtl.writeN;
        hiByte   = dataIn[8];
        readWord = result_r.value;
        if (TEN_BIT) begin
            readWord[1:0] = 2'h0;
        end
        dOut_nxt   = dOut_r;
        dOe_nxt    = 12'hfff;
        ctrl_nxt   = ctrl_r;
        ctrlLd_nxt = 1'b0;
        if (readStart) begin
            if (hostCtl.wordByteSel) begin
                dOut_nxt = readWord;
            end else if (hiByte) begin
                dOut_nxt = {4'h0, 1'b0, result_r.channel, 1'b0, readWord[11:8]};
            end else begin
                dOut_nxt = {4'h0, readWord[7:0]};
            end
        end
        if (reading) begin
            // Bit 8 is an input in byte mode
            dOe_nxt = hostCtl.wordByteSel ? 12'h000 : 12'hf00;
        end
        if (writing && !reading) begin
            ctrlLd_nxt = 1'b1;
            if (hostCtl.wordByteSel) begin
                ctrl_nxt = dataIn;
            end else if (hiByte) begin
                // Lines 4-7 assumed zero from the host
                ctrl_nxt = {dataIn[3:0], ctrl_r[7:0]};
            end else begin
                ctrl_nxt = {ctrl_r[11:8], dataIn[7:0]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dOut_r   <= 12'h000;
            dOe_r    <= 12'hfff;
            ctrl_r   <= `CTRL_RST;
            ctrlLd_r <= 1'b0;
        end else begin
            dOut_r   <= dOut_nxt;
            dOe_r    <= dOe_nxt;
            ctrl_r   <= ctrl_nxt;
            ctrlLd_r <= ctrlLd_nxt;
        end
    end

    assign dataOut     = dOut_r;
    assign dataOe      = dOe_r;
    assign busy        = busy_r;
    assign trackHold   = hold_r;
    assign poweredUp   = up_r;
    assign controlWord = ctrl_r;
    assign controlLoad = ctrlLd_r;

endmodule // adc_parallel_bus_interface

/* bench/adc_bus_properties.sv */
// Purpose: port assertions of the host port
// Assumes: one clock, sync reset
// Notes:   bound to the design top
`timescale 1ns/100ps
module adc_bus_properties (
    input wire logic                  clk,
    input wire logic                  rst,
    input wire adc_bus_pkg::host_ctl_s hostCtl,
    input wire logic [11:0]           dataIn,
    input wire logic [11:0]           dataOe,
    input wire logic                  conversion_start_n,
    input wire logic                  busy,
    input wire logic                  trackHold,
    input wire logic                  poweredUp,
    input wire logic [11:0]           controlWord,
    input wire logic                  controlLoad
);
    import adc_bus_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_busy_start: assert property ($fell(conversion_start_n) && !busy && poweredUp |=> busy)
        else $error("busy did not rise");
    a_busy_span: assert property ($rose(busy) |-> busy[*8] ##[19:1000] !busy)
        else $error("conversion length wrong");
    a_track_busy: assert property (trackHold == busy)
        else $error("hold and busy differ");
    a_oe_idle: assert property ($past(hostCtl.chipSelN) || $past(hostCtl.readN) |-> dataOe == 12'hfff)
        else $error("bus driven outside read");
    a_byte_upper: assert property (!$past(hostCtl.wordByteSel) |-> dataOe[11:8] == 4'hf)
        else $error("upper lines driven in byte mode");
    a_word_write: assert property (!hostCtl.chipSelN && !hostCtl.writeN && hostCtl.readN
        && hostCtl.wordByteSel |=> controlLoad && controlWord == $past(dataIn))
        else $error("word write not loaded");
    a_load_cause: assert property (controlLoad |-> !$past(hostCtl.writeN) && !$past(hostCtl.chipSelN))
        else $error("load without write");
    a_wake_up: assert property (!poweredUp && $rose(conversion_start_n) |=> poweredUp)
        else $error("no wake on start rise");
    cover property ($fell(busy));
    cover property (!poweredUp);
    cover property (controlLoad && !hostCtl.wordByteSel);
endmodule // adc_bus_properties

bind adc_parallel_bus_interface adc_bus_properties u_adc_bus_properties (.clk, .rst, .hostCtl,
    .dataIn, .dataOe, .conversion_start_n, .busy, .trackHold, .poweredUp, .controlWord, .controlLoad);

/* bench/host_bus_model.sv */
// Purpose: host side of the shared data bus
// Assumes: enables low while the device drives
// Notes:   undriven lines flip each cycle
`timescale 1ns/100ps
module host_bus_model (
    input wire logic        clk,
    input wire logic [11:0] hostDrv,
    input wire logic [11:0] hostData,
    input wire logic [11:0] dataOut,
    input wire logic [11:0] dataOe,
    output logic [11:0]     dataIn
);
    logic [11:0] lastSeen_r;
    always_ff @(posedge clk) lastSeen_r <= dataIn;
    // Floating lines must not look like stale data
    always_comb for (int i = 0; i < 12; i++)
        dataIn[i] = hostDrv[i] ? hostData[i] : (!dataOe[i] ? dataOut[i] : ~lastSeen_r[i]);
endmodule // host_bus_model

/* bench/tb_top.sv */
// Purpose: directed tests of the host port
// Assumes: default ten-bit parameter off
// Notes:   master clock toggles every cycle
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin fails++; \
    $display("mismatch %s exp %h got %h", n, e, a); end end
module tb_top;
    import adc_bus_pkg::*;
    logic        clk = 0, rst = 1, start = 1, mclk = 0, apd = 0;
    host_ctl_s   hostCtl = 4'hf;
    result_s     sampleIn = '0;
    logic [11:0] hostData = '0, hostDrv = '0, dataIn, dataOut, dataOe, controlWord;
    logic        busy, trackHold, poweredUp, controlLoad;
    int          fails = 0, checks = 0;
    always #20 clk = ~clk;
    always @(posedge clk) mclk <= ~mclk;
    adc_parallel_bus_interface u_adc_parallel_bus_interface (.clk, .rst, .hostCtl, .dataIn,
        .dataOut, .dataOe, .conversion_start_n(start), .master_clock_in(mclk), .sampleIn,
        .autoPowerDown(apd), .busy, .trackHold, .poweredUp, .controlWord, .controlLoad);
    host_bus_model u_host_bus_model (.clk, .hostDrv, .hostData, .dataOut, .dataOe, .dataIn);
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Held two edges so the one-cycle answer lag has landed
    task automatic xfer(input logic rd, input logic wb, input logic hb, input logic [11:0] d);
        hostCtl = {1'b0, ~rd, rd, wb};
        hostData = wb ? d : {3'h0, hb, d[7:0]};
        hostDrv = wb ? (rd ? 12'h000 : 12'hfff) : (rd ? 12'h100 : 12'h1ff);
        tick(2);
    endtask
    task automatic idle;
        hostCtl = 4'hf;
        hostDrv = '0;
        tick(2);
    endtask
    task automatic convert(input logic [11:0] v, input logic [1:0] ch);
        int n = 0;
        sampleIn = {v, ch};
        start = 0;
        tick(1);
        `CHK("busy rise", 1'b1, busy)
        start = 1;
        while (busy && n < 300) begin
            tick(1);
            n++;
        end
        `CHK("busy span", 1'b1, n >= 27 && n < 300)
        `CHK("tracking", 1'b0, trackHold)
        sampleIn = ~{v, ch};
    endtask
    task automatic word_read;
        convert(12'ha5c, 2'h2);
        xfer(1, 1, 0, 0);
        `CHK("word data", 12'ha5c, dataOut)
        `CHK("word oe", 12'h000, dataOe)
        idle;
        `CHK("released", 12'hfff, dataOe)
        xfer(1, 1, 0, 0);
        `CHK("reread", 12'ha5c, dataOut)
        idle;
        $display("word read done");
    endtask
    task automatic byte_read;
        convert(12'h3c7, 2'h1);
        xfer(1, 0, 0, 0);
        `CHK("low byte", 8'hc7, dataOut[7:0])
        `CHK("upper oe", 4'hf, dataOe[11:8])
        idle;
        xfer(1, 0, 1, 0);
        `CHK("high byte", 8'h23, dataOut[7:0])
        idle;
        $display("byte read done");
    endtask
    task automatic ctl_write;
        xfer(0, 1, 0, 12'h9a6);
        `CHK("word write", 12'h9a6, controlWord)
        `CHK("load pulse", 1'b1, controlLoad)
        idle;
        xfer(0, 0, 0, 12'h05b);
        idle;
        xfer(0, 0, 1, 12'h00e);
        `CHK("byte write", 12'he5b, controlWord)
        idle;
        $display("write done");
    endtask
    task automatic power_cycle;
        apd = 1;
        convert(12'h001, 2'h3);
        tick(1);
        `CHK("powered down", 1'b0, poweredUp)
        start = 0;
        tick(3);
        `CHK("start ignored", 1'b0, busy)
        start = 1;
        tick(2);
        `CHK("woken", 1'b1, poweredUp)
        apd = 0;
        $display("power cycle done");
    endtask
    task automatic print_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        tick(16);
        rst = 0;
        tick(1);
        word_read;
        byte_read;
        ctl_write;
        power_cycle;
        print_verdict;
    end
    initial begin
        #50000;
        fails++;
        print_verdict;
    end
endmodule // tb_top
